// File: design/tpl_probe_latch.sv
module tpl_probe_latch #(
  parameter int STEPS_PER_REV = tpl_pkg::STEPS_PER_REV_DEFAULT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ext_latch_in_a,
  input wire logic ext_latch_in_b,
  input wire logic signed [31:0] feedback_pos,
  input wire logic signed [31:0] command_pos,
  input wire logic rx_valid,
  input wire logic [15:0] receive_process_data,
  output tpl_pkg::tpl_tx_t transmit_process_data,
  input wire tpl_pkg::tpl_obj_req_t obj_req,
  output logic [31:0] obj_rdata,
  output logic obj_ack,
  output logic obj_err,
  output logic zero_position_out,
  output logic timing_pulse_out
);
  import tpl_pkg::*;

  logic [15:0] control_q;
  logic [7:0] latch_sel_q [2];
  logic [7:0] trig_sel_q [2];
  logic [1:0] ext_meta_q;
  logic [1:0] ext_sync_q;
  logic [1:0] ext_prev_q;
  logic zero_prev_q;
  logic tim_prev_q;
  logic zero_lvl;
  logic tim_lvl;
  logic signed [31:0] cap_rise_q [2];
  logic signed [31:0] cap_fall_q [2];
  logic [1:0] rise_done_q;
  logic [1:0] fall_done_q;

  // internal trigger sources, also driven out of the block
  tpl_shaft_signals #(
    .STEPS_PER_REV(STEPS_PER_REV)
  ) u_shaft (
    .clock(clock),
    .resetn(resetn),
    .command_pos(command_pos),
    .zero_position_out(zero_lvl),
    .timing_pulse_out(tim_lvl)
  );

  assign zero_position_out = zero_lvl;
  assign timing_pulse_out = tim_lvl;

  // control word: process data wins over an object write in the same cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      control_q <= CONTROL_RESET;
    end else if (rx_valid) begin
      control_q <= receive_process_data;
    end else if (obj_req.wr && obj_req.index == IDX_CONTROL) begin
      control_q <= {control_q[15:8], obj_req.wdata};
    end
  end

  // external pins cross into the drive clock through two flops
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ext_meta_q <= 2'h0;
      ext_sync_q <= 2'h0;
      ext_prev_q <= 2'h0;
      zero_prev_q <= 1'b0;
      tim_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= {ext_latch_in_b, ext_latch_in_a};
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      zero_prev_q <= zero_lvl;
      tim_prev_q <= tim_lvl;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam int B = c * CH_STRIDE;
    logic en_prev_q;
    logic cont_q;
    logic internal_q;
    logic rise_en_q;
    logic fall_en_q;
    logic use_cmd_q;
    logic use_tim_q;
    logic arm;
    logic active;
    logic src_now;
    logic src_prev;
    logic rise_ev;
    logic fall_ev;
    logic signed [31:0] pos;

    // selectors, one per channel
    always_ff @(posedge clock) begin
      if (!resetn) begin
        latch_sel_q[c] <= SEL_RESET;
        trig_sel_q[c] <= SEL_RESET;
      end else if (obj_req.wr) begin
        if (obj_req.index == (c == 0 ? IDX_LATCH_SEL_1 : IDX_LATCH_SEL_2)) begin
          latch_sel_q[c] <= obj_req.wdata;
        end
        if (obj_req.index == (c == 0 ? IDX_TRIG_SEL_1 : IDX_TRIG_SEL_2)) begin
          trig_sel_q[c] <= obj_req.wdata;
        end
      end
    end

    assign arm = control_q[B + CTL_ENABLE] && !en_prev_q;
    assign active = control_q[B + CTL_ENABLE] && en_prev_q;

    // setup is frozen at arming so edits under enable have no effect
    always_ff @(posedge clock) begin
      if (!resetn) begin
        en_prev_q <= 1'b0;
        cont_q <= 1'b0;
        internal_q <= 1'b0;
        rise_en_q <= 1'b0;
        fall_en_q <= 1'b0;
        use_cmd_q <= 1'b0;
        use_tim_q <= 1'b0;
      end else begin
        en_prev_q <= control_q[B + CTL_ENABLE];
        if (arm) begin
          cont_q <= control_q[B + CTL_CONTINUOUS];
          internal_q <= control_q[B + CTL_INTERNAL];
          rise_en_q <= control_q[B + CTL_RISE_EN];
          fall_en_q <= control_q[B + CTL_FALL_EN];
          use_cmd_q <= latch_sel_q[c] == SEL_ONE;
          use_tim_q <= trig_sel_q[c] == SEL_ONE;
        end
      end
    end

    // external input c serves channel c only
    always_comb begin
      if (!internal_q) begin
        src_now = ext_sync_q[c];
        src_prev = ext_prev_q[c];
        pos = use_cmd_q ? command_pos : feedback_pos;
      end else if (use_tim_q) begin
        src_now = tim_lvl;
        src_prev = tim_prev_q;
        pos = command_pos;
      end else begin
        src_now = zero_lvl;
        src_prev = zero_prev_q;
        pos = feedback_pos;
      end
    end

    assign rise_ev = active && rise_en_q && src_now && !src_prev;
    assign fall_ev = active && fall_en_q && !src_now && src_prev;

    // captured values persist after disable; flags clear on re-arm only
    always_ff @(posedge clock) begin
      if (!resetn) begin
        cap_rise_q[c] <= 32'sh0;
        cap_fall_q[c] <= 32'sh0;
        rise_done_q[c] <= 1'b0;
        fall_done_q[c] <= 1'b0;
      end else if (arm) begin
        rise_done_q[c] <= 1'b0;
        fall_done_q[c] <= 1'b0;
      end else begin
        if (rise_ev && (cont_q || !rise_done_q[c])) begin
          cap_rise_q[c] <= pos;
          rise_done_q[c] <= 1'b1;
        end
        if (fall_ev && (cont_q || !fall_done_q[c])) begin
          cap_fall_q[c] <= pos;
          fall_done_q[c] <= 1'b1;
        end
      end
    end
  end

  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    for (int c = 0; c < 2; c++) begin
      status[c * CH_STRIDE + STS_ENABLED] = control_q[c * CH_STRIDE + CTL_ENABLE];
      status[c * CH_STRIDE + STS_RISE_DONE] = rise_done_q[c];
      status[c * CH_STRIDE + STS_FALL_DONE] = fall_done_q[c];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      transmit_process_data <= '0;
    end else begin
      transmit_process_data.status <= status;
      transmit_process_data.cap_1_rise <= cap_rise_q[0];
      transmit_process_data.cap_1_fall <= cap_fall_q[0];
      transmit_process_data.cap_2_rise <= cap_rise_q[1];
      transmit_process_data.cap_2_fall <= cap_fall_q[1];
    end
  end

  // object access: one-cycle answer; writes to read-only or unknown indices err
  always_ff @(posedge clock) begin
    if (!resetn) begin
      obj_rdata <= 32'h0;
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
    end else begin
      obj_ack <= obj_req.rd || obj_req.wr;
      obj_err <= 1'b0;
      obj_rdata <= 32'h0;
      if (!(obj_req.rd || obj_req.wr)) begin
        obj_rdata <= 32'h0; // idle cycles read as zero whatever the index holds
      end else if (obj_req.index == IDX_LATCH_SEL_1) begin
        obj_rdata <= {24'h0, latch_sel_q[0]};
      end else if (obj_req.index == IDX_LATCH_SEL_2) begin
        obj_rdata <= {24'h0, latch_sel_q[1]};
      end else if (obj_req.index == IDX_TRIG_SEL_1) begin
        obj_rdata <= {24'h0, trig_sel_q[0]};
      end else if (obj_req.index == IDX_TRIG_SEL_2) begin
        obj_rdata <= {24'h0, trig_sel_q[1]};
      end else if (obj_req.index == IDX_CONTROL) begin
        obj_rdata <= {16'h0, control_q};
      end else if (obj_req.index == IDX_STATUS) begin
        obj_rdata <= {16'h0, status};
        obj_err <= obj_req.wr;
      end else if (obj_req.index == IDX_CAP_1_RISE) begin
        obj_rdata <= cap_rise_q[0];
        obj_err <= obj_req.wr;
      end else if (obj_req.index == IDX_CAP_1_FALL) begin
        obj_rdata <= cap_fall_q[0];
        obj_err <= obj_req.wr;
      end else if (obj_req.index == IDX_CAP_2_RISE) begin
        obj_rdata <= cap_rise_q[1];
        obj_err <= obj_req.wr;
      end else if (obj_req.index == IDX_CAP_2_FALL) begin
        obj_rdata <= cap_fall_q[1];
        obj_err <= obj_req.wr;
      end else begin
        obj_err <= obj_req.rd || obj_req.wr;
      end
    end
  end
endmodule : tpl_probe_latch

// File: design/tpl_pkg.sv
package tpl_pkg;
  // object indices
  localparam logic [15:0] IDX_LATCH_SEL_1 = 16'h44b0;
  localparam logic [15:0] IDX_LATCH_SEL_2 = 16'h44b1;
  localparam logic [15:0] IDX_TRIG_SEL_1 = 16'h44b2;
  localparam logic [15:0] IDX_TRIG_SEL_2 = 16'h44b3;
  localparam logic [15:0] IDX_CONTROL = 16'h60b8;
  localparam logic [15:0] IDX_STATUS = 16'h60b9;
  localparam logic [15:0] IDX_CAP_1_RISE = 16'h60ba;
  localparam logic [15:0] IDX_CAP_1_FALL = 16'h60bb;
  localparam logic [15:0] IDX_CAP_2_RISE = 16'h60bc;
  localparam logic [15:0] IDX_CAP_2_FALL = 16'h60bd;

  // reset values, and the selector code that picks command position or timing pulse
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] SEL_ONE = 8'h01;

  // control word fields, channel one; channel two sits CH_STRIDE bits higher
  localparam int CH_STRIDE = 8;
  localparam int CTL_ENABLE = 0;
  localparam int CTL_CONTINUOUS = 1;
  localparam int CTL_INTERNAL = 2;
  localparam int CTL_RISE_EN = 4;
  localparam int CTL_FALL_EN = 5;

  // status word fields, channel one
  localparam int STS_ENABLED = 0;
  localparam int STS_RISE_DONE = 1;
  localparam int STS_FALL_DONE = 2;

  // timing pulse: one per 7.2 degrees of shaft, i.e. 50 per revolution
  localparam int TIM_PER_REV = 50;
  localparam int STEPS_PER_REV_DEFAULT = 10000;

  typedef struct packed {
    logic [15:0] status;
    logic signed [31:0] cap_1_rise;
    logic signed [31:0] cap_1_fall;
    logic signed [31:0] cap_2_rise;
    logic signed [31:0] cap_2_fall;
  } tpl_tx_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] index;
    logic [7:0] wdata;
  } tpl_obj_req_t;
endpackage : tpl_pkg

// File: design/tpl_shaft_signals.sv
module tpl_shaft_signals #(
  parameter int STEPS_PER_REV = tpl_pkg::STEPS_PER_REV_DEFAULT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic signed [31:0] command_pos,
  output logic zero_position_out,
  output logic timing_pulse_out
);
  import tpl_pkg::*;

  localparam int TIM_STEPS = STEPS_PER_REV / TIM_PER_REV;

  initial begin
    if (STEPS_PER_REV % TIM_PER_REV != 0 || STEPS_PER_REV < TIM_PER_REV) begin
      $error("steps per revolution must be a nonzero multiple of the timing count");
    end
  end

  // both outputs are high while the command position sits on a mark;
  // crossing a mark gives a rise and a fall, one per mark
  always_ff @(posedge clock) begin
    if (!resetn) begin
      zero_position_out <= 1'b0;
      timing_pulse_out <= 1'b0;
    end else begin
      zero_position_out <= (command_pos % STEPS_PER_REV) == 0;
      timing_pulse_out <= (command_pos % TIM_STEPS) == 0;
    end
  end
endmodule : tpl_shaft_signals

// File: dv/tpl_master_model.sv
module tpl_master_model (
  input wire logic clock,
  output logic rx_valid,
  output logic [15:0] receive_process_data,
  output tpl_pkg::tpl_obj_req_t obj_req,
  input wire logic [31:0] obj_rdata,
  input wire logic obj_ack,
  input wire logic obj_err
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpl_pkg::*;
  initial begin
    rx_valid = 1'b0;
    receive_process_data = CONTROL_RESET;
    obj_req = '0;
  end
  // one strobe per load; data is inverted afterwards so a stale word cannot pass
  // a new setup takes effect only after enable has dropped; a setup loaded while enabled is ignored
  task automatic ctl_load(input logic [15:0] v);
    @(posedge clock);
    rx_valid <= 1'b1;
    receive_process_data <= v;
    @(posedge clock);
    rx_valid <= 1'b0;
    receive_process_data <= ~v;
  endtask : ctl_load
  task automatic obj_xfer(input logic w, input logic [15:0] i, input logic [7:0] v,
                          output logic [31:0] dat, output logic [1:0] ae);
    @(posedge clock);
    obj_req <= '{rd: !w, wr: w, index: i, wdata: v};
    @(posedge clock);
    obj_req <= '{rd: 1'b0, wr: 1'b0, index: ~i, wdata: ~v};
    @(posedge clock);
    dat = obj_rdata;
    ae = {obj_ack, obj_err};
  endtask : obj_xfer
endmodule : tpl_master_model

// File: dv/tpl_probe_latch_asserts.sv
module tpl_probe_latch_asserts #(
  parameter int STEPS_PER_REV = 100
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic signed [31:0] command_pos,
  input wire logic rx_valid,
  input wire logic [15:0] receive_process_data,
  input wire tpl_pkg::tpl_tx_t transmit_process_data,
  input wire tpl_pkg::tpl_obj_req_t obj_req,
  input wire logic [31:0] obj_rdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic zero_position_out,
  input wire logic timing_pulse_out
);
  import tpl_pkg::*;
  localparam int TIM_STEPS = STEPS_PER_REV / TIM_PER_REV;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic req;
  logic ro;
  logic known;
  assign req = obj_req.rd || obj_req.wr;
  assign ro = obj_req.index inside {[IDX_STATUS:IDX_CAP_2_FALL]};
  assign known = ro || obj_req.index inside {[IDX_LATCH_SEL_1:IDX_TRIG_SEL_2], IDX_CONTROL};
  property p_ack_follows; req |=> obj_ack; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no ack after request");
  property p_idle_quiet; !req |=> !obj_ack && obj_rdata == 32'h0; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("stray ack or data");
  property p_ro_refused; obj_req.wr && ro |=> obj_err; endproperty
  a_ro_refused: assert property (p_ro_refused) else $error("read-only write taken");
  property p_unknown_refused; req && !known |=> obj_err && obj_rdata == 32'h0; endproperty
  a_unknown_refused: assert property (p_unknown_refused) else $error("unknown index");
  property p_known_read; obj_req.rd && known |=> !obj_err; endproperty
  a_known_read: assert property (p_known_read) else $error("read refused");
  property p_sts_reserved; (transmit_process_data.status & 16'hf8f8) == 16'h0000; endproperty
  a_sts_reserved: assert property (p_sts_reserved) else $error("reserved status bit");
  property p_enabled_mirror;
    rx_valid |-> ##2 transmit_process_data.status[8] == $past(receive_process_data[8], 2)
      && transmit_process_data.status[0] == $past(receive_process_data[0], 2);
  endproperty
  a_enabled_mirror: assert property (p_enabled_mirror) else $error("enabled status");
  property p_zero_mark;
    $past(resetn) |-> zero_position_out == ($past(command_pos) % STEPS_PER_REV == 0);
  endproperty
  a_zero_mark: assert property (p_zero_mark) else $error("zero output wrong");
  property p_timing_mark;
    $past(resetn) |-> timing_pulse_out == ($past(command_pos) % TIM_STEPS == 0);
  endproperty
  a_timing_mark: assert property (p_timing_mark) else $error("timing output wrong");
  c_refused: cover property (obj_err);
  c_rise_latched: cover property (transmit_process_data.status[1]);
  c_ch2_latched: cover property (transmit_process_data.status[9]);
endmodule : tpl_probe_latch_asserts
bind tpl_probe_latch tpl_probe_latch_asserts #(.STEPS_PER_REV(STEPS_PER_REV)) chk_u (
  .clock(clock), .resetn(resetn), .command_pos(command_pos), .rx_valid(rx_valid),
  .receive_process_data(receive_process_data), .transmit_process_data(transmit_process_data),
  .obj_req(obj_req), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
  .zero_position_out(zero_position_out), .timing_pulse_out(timing_pulse_out)
);

// File: dv/tpl_probe_latch_tb.sv
module tpl_probe_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpl_pkg::*;
  logic clock = 1'b0;
  logic resetn;
  logic ext_a;
  logic ext_b;
  logic signed [31:0] feedback_pos;
  logic signed [31:0] command_pos;
  logic zero_out;
  logic tim_out;
  logic rx_valid;
  logic [15:0] rx_data;
  tpl_tx_t tx;
  tpl_obj_req_t obj_req;
  logic [31:0] obj_rdata;
  logic obj_ack;
  logic obj_err;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] dat;
  logic [31:0] fb;
  logic [31:0] cm;
  logic [31:0] old;
  logic [1:0] ae;
  logic [7:0] v;
  always #5 clock = ~clock;
  tpl_probe_latch #(.STEPS_PER_REV(100)) dut_u (.clock(clock), .resetn(resetn),
    .ext_latch_in_a(ext_a), .ext_latch_in_b(ext_b), .feedback_pos(feedback_pos),
    .command_pos(command_pos), .rx_valid(rx_valid), .receive_process_data(rx_data),
    .transmit_process_data(tx), .obj_req(obj_req), .obj_rdata(obj_rdata),
    .obj_ack(obj_ack), .obj_err(obj_err), .zero_position_out(zero_out),
    .timing_pulse_out(tim_out));
  tpl_master_model master_u (.clock(clock), .rx_valid(rx_valid), .receive_process_data(rx_data),
    .obj_req(obj_req), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));
  task automatic finish_test;
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // the selector only counts for external pins; zero takes feedback, timing command
  function automatic logic [31:0] exp_pos(input logic ext, input logic [7:0] sel,
                                          input logic [31:0] f, input logic [31:0] c);
    return (ext ? sel == SEL_ONE : sel == 8'h02) ? c : f;
  endfunction : exp_pos
  task automatic wr8(input logic [15:0] i, input logic [7:0] d);
    master_u.obj_xfer(1'b1, i, d, dat, ae);
  endtask : wr8
  task automatic pin(input bit b, input logic lv);
    fb = $urandom;
    cm = $urandom;
    @(posedge clock);
    feedback_pos <= fb;
    command_pos <= cm;
    if (b) ext_b <= lv;
    else ext_a <= lv;
    repeat (6) @(posedge clock);
  endtask : pin
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    resetn = 1'b0;
    ext_a = 1'b0;
    ext_b = 1'b0;
    feedback_pos = 32'sh0;
    command_pos = 32'sh1;
    dat = $urandom(32'h80ae);
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      master_u.obj_xfer(1'b0, i < 4 ? 16'(IDX_LATCH_SEL_1 + i) : IDX_CONTROL, 8'h00, dat, ae);
      chk({30'h0, ae}, 32'h2);
      chk(dat, 32'h0);
      v = $urandom;
      wr8(i < 4 ? 16'(IDX_LATCH_SEL_1 + i) : IDX_CAP_1_RISE, v);
      chk({30'h0, ae}, i < 4 ? 32'h2 : 32'h3);
      master_u.obj_xfer(1'b0, i < 4 ? 16'(IDX_LATCH_SEL_1 + i) : IDX_CAP_1_RISE, 8'h00, dat,
                        ae);
      chk(dat, i < 4 ? {24'h0, v} : 32'h0);
    end
    master_u.obj_xfer(1'b1, IDX_STATUS, 8'h5a, dat, ae);
    chk(ae, 2'b11);
    master_u.obj_xfer(1'b0, 16'h1234, 8'h00, dat, ae);
    chk({30'h0, ae}, 32'h3);
    chk(dat, 32'h0);
    wr8(IDX_LATCH_SEL_1, SEL_RESET);
    master_u.ctl_load(16'h0011);
    pin(0, 1'b1);
    chk(tx.cap_1_rise, exp_pos(1, SEL_RESET, fb, cm));
    old = fb;
    pin(0, 1'b0);
    chk(tx.status, 16'h0003);
    master_u.ctl_load(16'h0013);
    pin(0, 1'b1);
    chk(tx.cap_1_rise, old);
    master_u.ctl_load(16'h0000);
    wr8(IDX_LATCH_SEL_1, SEL_ONE);
    master_u.ctl_load(16'h0033);
    for (int i = 0; i < 6; i++) begin
      pin(0, i[0]);
      chk(i[0] ? tx.cap_1_rise : tx.cap_1_fall, exp_pos(1, SEL_ONE, fb, cm));
    end
    old = cm;
    pin(1, 1'b1);
    chk({16'h0, tx.status}, 32'h7);
    chk(tx.cap_1_rise, old);
    master_u.ctl_load(16'h0000);
    master_u.ctl_load(16'h0011);
    // park off every mark so the later mark steps give a real rising edge
    command_pos <= 32'sh1;
    repeat (3) @(posedge clock);
    chk(tx.status, 16'h0001);
    wr8(IDX_LATCH_SEL_2, SEL_RESET);
    wr8(IDX_TRIG_SEL_2, SEL_ONE);
    master_u.ctl_load(16'h1711);
    fb = $urandom;
    cm = $urandom & 32'h0fff_fff0 | 32'h2;
    command_pos <= cm;
    feedback_pos <= fb;
    repeat (6) @(posedge clock);
    chk(tx.cap_2_rise, exp_pos(0, 8'h02, fb, cm));
    chk(tx.status[10:8], 3'b011);
    chk({30'h0, zero_out, tim_out}, 32'h1);
    master_u.ctl_load(16'h0011);
    wr8(IDX_LATCH_SEL_2, SEL_ONE);
    wr8(IDX_TRIG_SEL_2, SEL_RESET);
    master_u.ctl_load(16'h1511);
    cm = ($urandom % 1000) * 100;
    command_pos <= cm;
    repeat (6) @(posedge clock);
    chk(tx.cap_2_rise, exp_pos(0, SEL_RESET, fb, cm));
    chk({30'h0, zero_out, tim_out}, 32'h3);
    finish_test();
  end
endmodule : tpl_probe_latch_tb
